/* hw/ict_map.svh */
/*
  Constants for the instruction-cycle timing block: field positions in the
  24-bit program word, operand limits, cycle counts and reset values.
  Assumes it is included by the package only, once per compile.
*/
`ifndef ICT_MAP_SVH
`define ICT_MAP_SVH

// ==========================================================
// Program word layout
`define ICT_WORD_W 24
`define ICT_HI_MSB 23
`define ICT_HI_LSB 16
`define ICT_HI_ZERO 8'h00
`define ICT_TEN_LIT_LSB 4
`define ICT_STEN_LIT_LSB 4
`define ICT_FADDR_LSB 0
`define ICT_BITSEL_LSB 12
`define ICT_WB_SEL_BIT 16
`define ICT_PADDR_HI_LSB 0

// ==========================================================
// Operand limits
`define ICT_BYTE_LIT_MAX 10'h0ff
`define ICT_WORD_LIT_MAX 10'h3ff
`define ICT_FADDR_MAX 13'h1fff

// ==========================================================
// Cycle counts per instruction
`define ICT_CYC_ONE 2'h1
`define ICT_CYC_TWO 2'h2
`define ICT_CYC_THREE 2'h3

// ==========================================================
// Write-back pointer
`define ICT_PTR_STEP 16'h0002
`define ICT_PTR_RST 16'h0000

`endif

/* hw/ict_pkg.sv */
/*
  Types for the instruction-cycle timing block: sequencer states,
  instruction classes and the packed state records of the flag and core modules.
  Assumes ict_map.svh is on the include path.
*/
`include "ict_map.svh"

package ict_pkg;

  // ==========================================================
  // Enumerations
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_STALL = 2'b01,
    ST_SECOND = 2'b10,
    ST_SQUASH = 2'b11
  } ict_state_e;

  typedef enum logic [3:0] {
    CL_PLAIN = 4'b0000,
    CL_COND = 4'b0001,
    CL_JUMP = 4'b0010,
    CL_INDIRECT = 4'b0011,
    CL_TABLE = 4'b0100,
    CL_RETURN = 4'b0101,
    CL_SKIP = 4'b0110,
    CL_DMOVE = 4'b0111,
    CL_DOUBLE = 4'b1000,
    CL_PCWRITE = 4'b1001
  } ict_class_e;

  // ==========================================================
  // State records
  typedef struct packed {
    logic c;
    logic dc;
    logic n;
    logic ov;
    logic z;
    logic ovf_a;
    logic ovf_b;
    logic clip_a;
    logic clip_b;
  } ict_flags_s;

  typedef struct packed {
    ict_state_e state;
    logic [1:0] cnt;
    logic [`ICT_WORD_W-1:0] held;
    logic commit;
    logic nop;
    logic bad_pair;
    logic [47:0] opnd;
    logic [9:0] ten_lit;
    logic [22:0] paddr;
    logic paddr_odd;
    logic [15:0] slit;
    logic [12:0] faddr;
    logic [15:0] bitsel;
    logic wb_to_mem;
    logic [15:0] wb_ptr;
  } ict_core_s;

endpackage : ict_pkg

/* hw/ict_fields.sv */
/*
  Operand field extraction for one instruction (one or two words).
  Purely combinational; the sequencer registers the results at commit.
*/
`timescale 1ns/10ps
`default_nettype none

module ict_fields
  import ict_pkg::*;
(
  input wire logic [`ICT_WORD_W-1:0] word_a,
  input wire logic [`ICT_WORD_W-1:0] word_b,
  input wire logic byte_mode,
  output logic [9:0] ten_lit,
  output logic [22:0] paddr,
  output logic paddr_odd,
  output logic [15:0] slit,
  output logic [12:0] faddr,
  output logic [15:0] bitsel,
  output logic wb_to_mem
);

  logic [9:0] raw10;
  logic [9:0] sraw;
  logic [22:0] praw;

  // ==========================================================
  // Literal and address fields
  always_comb begin
    raw10 = word_a[`ICT_TEN_LIT_LSB +: 10];
    sraw = word_a[`ICT_STEN_LIT_LSB +: 10];
    praw = {word_b[`ICT_PADDR_HI_LSB +: 7], word_a[15:0]};
    // Byte mode masks to the low 8 bits so no stray high bits reach the ALU
    ten_lit = raw10 & (byte_mode ? `ICT_BYTE_LIT_MAX : `ICT_WORD_LIT_MAX); // [RQ9]
    paddr = {praw[22:1], 1'b0}; // [RQ10]
    paddr_odd = praw[0]; // [RQ10]
    slit = {{6{sraw[9]}}, sraw}; // [RQ14]
    faddr = word_a[`ICT_FADDR_LSB +: 13] & `ICT_FADDR_MAX; // [RQ11]
    bitsel = 16'h0001 << word_a[`ICT_BITSEL_LSB +: 4]; // [RQ13]
    wb_to_mem = word_a[`ICT_WB_SEL_BIT]; // [RQ12]
  end

endmodule : ict_fields

`default_nettype wire

/* hw/ict_flags.sv */
/*
  General and DSP status flags. Updated only on the commit cycle of an
  instruction, never during inserted no-operation cycles.
*/
`timescale 1ns/10ps
`default_nettype none

module ict_flags
  import ict_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic commit,
  input wire logic upd_mcu,
  input wire logic chain,
  input wire logic res_c,
  input wire logic res_dc,
  input wire logic res_n,
  input wire logic res_ov,
  input wire logic res_zero,
  input wire logic upd_dsp,
  input wire logic acc_sel,
  input wire logic acc_ovf,
  input wire logic acc_sat,
  output ict_flags_s flags
);

  ict_flags_s f_reg;
  ict_flags_s f_next;

  // ==========================================================
  // Next-state of flags
  always_comb begin
    f_next = f_reg;
    if (commit && upd_mcu) begin // [RQ17]
      f_next.c = res_c; // [RQ15]
      f_next.dc = res_dc;
      f_next.n = res_n;
      f_next.ov = res_ov;
      // Chained ops may only clear zero, so multiword compares work
      f_next.z = chain ? (f_reg.z & res_zero) : res_zero; // [RQ15]
    end
    if (commit && upd_dsp) begin
      if (acc_sel) begin
        f_next.ovf_b = acc_ovf; // [RQ16]
        f_next.clip_b = acc_sat;
      end else begin
        f_next.ovf_a = acc_ovf; // [RQ16]
        f_next.clip_a = acc_sat;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      f_reg <= '0;
    end else begin
      f_reg <= f_next;
    end
  end

  assign flags = f_reg;

endmodule : ict_flags

`default_nettype wire

/* hw/ict_core.sv */
/*
  Instruction-cycle sequencer: accepts program words from fetch, pairs
  double-word instructions, inserts no-operation cycles for branches,
  skips and multi-cycle instructions, registers operand fields and keeps
  the write-back pointer and status flags.
  Assumes a decoder on the same clock supplies the class and condition
  inputs alongside each word, and fetch honours instr_ready.
  Assumes flag results arrive with the word that commits, and that
  every input is already on clk, so nothing is synchronised here.
  Limitation: one instruction in flight, no overlap of stalls.
  A lone extension word and a true no-operation look the same and
  are handled the same. Unknown class codes run as plain ones.
  Fields of a malformed pair are dropped along with both words.
*/
`timescale 1ns/10ps
`default_nettype none

// How it works
// RQ1 - Instructions are one word; selected ones take two words, 48 bits.
// RQ2 - Second word of a pair has its upper eight bits zero.
// RQ3 - A lone second word executes as a no-operation, no side effects.
// RQ4 - Single-word: one cycle; two when condition true or PC changes.
// RQ5 - Jumps, indirect call/goto, table access, returns take two or three.
// RQ6 - Taken skip: two cycles over one word, three over two words.
// RQ7 - Double-width move takes two cycles.
// RQ8 - Two-word instructions complete in two cycles.
// RQ9 - Ten-bit literal limited to 255 in byte mode, 1023 in word mode.
// RQ10 - Program address literal is 23 bits with bit zero forced zero.
// RQ11 - File address covers zero to 0x1fff.
// RQ12 - Write-back goes to pointer or its target, pointer plus two.
// RQ13 - Four-bit field selects bit 0 to 15 of a word.
// RQ14 - Signed ten-bit literal is two's complement, -512 to 511.
// RQ15 - Carry, digit carry, negative, overflow and sticky zero flags.
// RQ16 - Overflow and saturation recorded per accumulator.
// RQ17 - Inserted cycles stall fetch and change no architectural state.
module ict_core
  import ict_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,

  // Fetch side and decoder qualifiers
  input wire logic instr_valid,
  input wire logic [`ICT_WORD_W-1:0] instr_word,
  input wire ict_class_e instr_class,
  input wire logic cond_true,
  input wire logic long_form,
  input wire logic skip_taken,
  input wire logic skip_two_word,
  input wire logic byte_mode,

  // Flag results from the datapath
  input wire logic upd_mcu,
  input wire logic chain,
  input wire logic res_c,
  input wire logic res_dc,
  input wire logic res_n,
  input wire logic res_ov,
  input wire logic res_zero,
  input wire logic upd_dsp,
  input wire logic acc_sel,
  input wire logic acc_ovf,
  input wire logic acc_sat,

  // Fetch handshake and sequencer pulses
  output logic instr_ready,
  output logic commit,
  output logic exec_nop,
  output logic bad_pair,

  // Operand fields, registered at commit
  output logic [47:0] operand_pair,
  output logic [9:0] ten_bit_literal,
  output logic [22:0] program_address_literal,
  output logic address_was_odd,
  output logic [15:0] signed_ten_bit_literal,
  output logic [12:0] file_address,
  output logic [15:0] bit_select_field,
  output logic acc_writeback_target,
  output logic [15:0] writeback_pointer_reg,

  // Status flags
  output logic carry_flag,
  output logic digit_carry_flag,
  output logic negative_flag,
  output logic overflow_flag,
  output logic zero_flag,
  output logic acc_a_overflow_flag,
  output logic acc_b_overflow_flag,
  output logic acc_a_clipped_flag,
  output logic acc_b_clipped_flag
);

  // ==========================================================
  // Cycle count of a non-skip, single-word instruction
  function automatic logic [1:0] cycles_for(
    input ict_class_e cls,
    input logic cnd,
    input logic lng
  );
    logic [1:0] cyc;
    // Skips and pairs are sized by the sequencer, not here
    cyc = `ICT_CYC_ONE;
    case (cls)
      CL_PLAIN: cyc = `ICT_CYC_ONE; // [RQ4]
      CL_COND: cyc = cnd ? `ICT_CYC_TWO : `ICT_CYC_ONE; // [RQ4]
      CL_PCWRITE: cyc = `ICT_CYC_TWO; // [RQ4]
      CL_JUMP,
      CL_INDIRECT,
      CL_TABLE,
      CL_RETURN: cyc = lng ? `ICT_CYC_THREE : `ICT_CYC_TWO; // [RQ5]
      CL_DMOVE: cyc = `ICT_CYC_TWO; // [RQ7]
      default: cyc = `ICT_CYC_ONE;
    endcase
    return cyc;
  endfunction : cycles_for

  // ==========================================================
  // Extension word test: upper byte clear
  function automatic logic is_ext_word(
    input logic [`ICT_WORD_W-1:0] wd
  );
    return (wd[`ICT_HI_MSB:`ICT_HI_LSB] == `ICT_HI_ZERO);
  endfunction : is_ext_word

  // ==========================================================
  // Declarations
  // Sequencer state, its next value and the flag record
  ict_core_s r_reg;
  ict_core_s r_next;
  ict_flags_s flags;

  // Decode of the word in hand
  logic take;
  logic [1:0] total;
  logic hi_zero;
  logic [`ICT_WORD_W-1:0] word_a;
  logic [`ICT_WORD_W-1:0] word_b;

  // Field extractor results, registered only on take
  logic [9:0] f_ten_lit;
  logic [22:0] f_paddr;
  logic f_odd;
  logic [15:0] f_slit;
  logic [12:0] f_faddr;
  logic [15:0] f_bitsel;
  logic f_wb_sel;

  // ==========================================================
  // Word pairing for field extraction
  // A pair puts the first word in word_a and its extension in word_b
  // Outside a pair word_b is zero, so single-word fields read clean
  always_comb begin
    if (r_reg.state == ST_SECOND) begin
      word_a = r_reg.held; // [RQ1]
      word_b = instr_word;
    end else begin
      word_a = instr_word;
      word_b = '0;
    end
  end

  assign hi_zero = is_ext_word(instr_word); // [RQ2] [RQ3]

  // Extraction is combinational; values count only when take registers them
  // byte_mode is taken with the word that commits, the second of a pair
  ict_fields u_fields (
    .word_a(word_a),
    .word_b(word_b),
    .byte_mode(byte_mode),
    .ten_lit(f_ten_lit),
    .paddr(f_paddr),
    .paddr_odd(f_odd),
    .slit(f_slit),
    .faddr(f_faddr),
    .bitsel(f_bitsel),
    .wb_to_mem(f_wb_sel)
  );

  // ==========================================================
  // Fetch handshake
  // Fetch only stalls in inserted cycles; squashed words still flow
  // Squashed words must leave fetch, so ready stays high while they do
  // Combinational, so a stall holds fetch off in the cycle it starts
  assign instr_ready = (r_reg.state != ST_STALL); // [RQ17]

  // ==========================================================
  // Sequencer next state
  // ST_RUN: takes one word a cycle and works out its length
  // ST_STALL: fetch held off, one no-op a cycle until cnt runs out
  // ST_SECOND: waits for the extension word of a pair
  // ST_SQUASH: fetch runs, each word taken is dropped as a no-op
  // Fields and flags move only with take, so inserted cycles stay inert
  always_comb begin
    r_next = r_reg;
    r_next.commit = 1'b0;
    r_next.nop = 1'b0;
    r_next.bad_pair = 1'b0;
    take = 1'b0;
    total = `ICT_CYC_ONE;
    unique case (r_reg.state)
      ST_RUN: begin
        if (instr_valid) begin
          if (hi_zero) begin
            // Lone extension word behaves as a no-operation
            r_next.nop = 1'b1; // [RQ3]
          end else if (instr_class == CL_DOUBLE) begin
            // First half of a pair: hold it, the answer follows the second
            r_next.held = instr_word; // [RQ1]
            r_next.state = ST_SECOND; // [RQ8]
          end else begin
            take = 1'b1;
            total = cycles_for(instr_class, cond_true, long_form);
            if (instr_class == CL_SKIP && skip_taken) begin
              // Skipped words are fetched and dropped, one per cycle
              r_next.cnt = skip_two_word ? `ICT_CYC_TWO : `ICT_CYC_ONE; // [RQ6]
              r_next.state = ST_SQUASH;
            end else if (total != `ICT_CYC_ONE) begin
              r_next.cnt = total - `ICT_CYC_ONE; // [RQ4] [RQ5] [RQ7]
              r_next.state = ST_STALL;
            end
          end
        end
      end

      ST_STALL: begin
        // Inserted cycle: fetch held off and nothing commits
        r_next.nop = 1'b1; // [RQ17]
        r_next.cnt = r_reg.cnt - `ICT_CYC_ONE;
        if (r_reg.cnt == `ICT_CYC_ONE) begin
          r_next.state = ST_RUN;
        end
      end

      ST_SECOND: begin
        // Pairing waits for whatever word fetch offers next
        if (instr_valid) begin
          r_next.state = ST_RUN;
          if (!hi_zero) begin
            // Malformed pair: drop both words rather than act on junk
            r_next.bad_pair = 1'b1; // [RQ2]
            r_next.nop = 1'b1;
          end else begin
            take = 1'b1; // [RQ8]
          end
        end
      end

      ST_SQUASH: begin
        // Counts words dropped, not cycles, so a slow fetch is fine
        if (instr_valid) begin
          r_next.nop = 1'b1; // [RQ6] [RQ17]
          r_next.cnt = r_reg.cnt - `ICT_CYC_ONE;
          if (r_reg.cnt == `ICT_CYC_ONE) begin
            r_next.state = ST_RUN;
          end
        end
      end
    endcase
    // Architectural updates happen only on the commit cycle
    if (take) begin
      r_next.commit = 1'b1; // [RQ17]
      r_next.opnd = {word_a, word_b}; // [RQ1]
      r_next.ten_lit = f_ten_lit; // [RQ9]
      r_next.paddr = f_paddr; // [RQ10]
      r_next.paddr_odd = f_odd;
      r_next.slit = f_slit; // [RQ14]
      r_next.faddr = f_faddr; // [RQ11]
      r_next.bitsel = f_bitsel; // [RQ13]
      r_next.wb_to_mem = f_wb_sel;
      // Pointer steps only when the memory target is chosen
      if (f_wb_sel) begin
        r_next.wb_ptr = r_reg.wb_ptr + `ICT_PTR_STEP; // [RQ12]
      end
    end
  end

  // ==========================================================
  // State register
  // Reset leaves the sequencer idle and ready for the first word
  always_ff @(posedge clk) begin
    if (srst) begin
      r_reg <= '0;
      r_reg.state <= ST_RUN;
      r_reg.wb_ptr <= `ICT_PTR_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // ==========================================================
  // Status flags, written only with the commit of an instruction
  // Results are sampled on the take edge, with the word that commits
  // Flag inputs during inserted cycles are ignored
  ict_flags u_flags (
    .clk(clk),
    .srst(srst),
    .commit(take),
    .upd_mcu(upd_mcu),
    .chain(chain),
    .res_c(res_c),
    .res_dc(res_dc),
    .res_n(res_n),
    .res_ov(res_ov),
    .res_zero(res_zero),
    .upd_dsp(upd_dsp),
    .acc_sel(acc_sel),
    .acc_ovf(acc_ovf),
    .acc_sat(acc_sat),
    .flags(flags)
  );

  // ==========================================================
  // Outputs
  // Every data output comes straight from a flop
  assign commit = r_reg.commit;
  assign exec_nop = r_reg.nop;
  assign bad_pair = r_reg.bad_pair;

  // Operand fields, held until the next commit
  assign operand_pair = r_reg.opnd;
  assign ten_bit_literal = r_reg.ten_lit;
  assign program_address_literal = r_reg.paddr;
  assign address_was_odd = r_reg.paddr_odd;
  assign signed_ten_bit_literal = r_reg.slit;
  assign file_address = r_reg.faddr;
  assign bit_select_field = r_reg.bitsel;
  assign acc_writeback_target = r_reg.wb_to_mem;
  assign writeback_pointer_reg = r_reg.wb_ptr;

  // Status flags
  assign carry_flag = flags.c;
  assign digit_carry_flag = flags.dc;
  assign negative_flag = flags.n;
  assign overflow_flag = flags.ov;
  assign zero_flag = flags.z;
  assign acc_a_overflow_flag = flags.ovf_a;
  assign acc_b_overflow_flag = flags.ovf_b;
  assign acc_a_clipped_flag = flags.clip_a;
  assign acc_b_clipped_flag = flags.clip_b;

endmodule : ict_core

`default_nettype wire

/* tb/ict_core_checker.sv */
/*
  Port-level checker for ict_core: take/commit timing, stall length,
  operand field limits, write-back pointer and status flag relations.
  Assumes one clock clk and synchronous active-high srst; bound below.
*/
`timescale 1ns/10ps
`default_nettype none

module ict_core_checker
  import ict_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic instr_valid,
  input wire logic instr_ready,
  input wire logic [23:0] instr_word,
  input wire ict_class_e instr_class,
  input wire logic long_form,
  input wire logic byte_mode,
  input wire logic upd_mcu,
  input wire logic chain,
  input wire logic upd_dsp,
  input wire logic acc_sel,
  input wire logic commit,
  input wire logic exec_nop,
  input wire logic bad_pair,
  input wire logic [47:0] operand_pair,
  input wire logic [9:0] ten_bit_literal,
  input wire logic [22:0] program_address_literal,
  input wire logic [12:0] file_address,
  input wire logic [15:0] bit_select_field,
  input wire logic acc_writeback_target,
  input wire logic [15:0] writeback_pointer_reg,
  input wire logic zero_flag,
  input wire logic acc_b_overflow_flag,
  input wire logic acc_b_clipped_flag
);
  // ==========================================================
  // Sequences and properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_long_take;
    instr_valid && instr_ready && instr_class == CL_JUMP && long_form && instr_word[23:16] != 8'h00;
  endsequence
  sequence s_stall2;
    !instr_ready [*2] ##1 instr_ready;
  endsequence
  property p_long; s_long_take |=> s_stall2; endproperty
  property p_take; commit |-> $past(instr_valid && instr_ready); endproperty
  property p_excl; !(commit && exec_nop); endproperty
  property p_bad; bad_pair |-> exec_nop && !commit; endproperty
  property p_hold; !commit |-> $stable(file_address) && $stable(operand_pair); endproperty
  property p_byte; commit && $past(byte_mode) |-> ten_bit_literal[9:8] == 2'b00; endproperty
  property p_even; program_address_literal[0] == 1'b0; endproperty
  property p_bit;
    commit && $past(instr_class) == CL_PLAIN |->
      bit_select_field == (16'h0001 << $past(instr_word[15:12]));
  endproperty
  property p_ptr;
    commit && acc_writeback_target |->
      writeback_pointer_reg == $past(writeback_pointer_reg) + 16'h0002;
  endproperty
  property p_zero; commit && $past(upd_mcu && chain) |-> !(zero_flag && !$past(zero_flag)); endproperty
  property p_dsp;
    commit && $past(upd_dsp && !acc_sel) |->
      $stable(acc_b_overflow_flag) && $stable(acc_b_clipped_flag);
  endproperty

  // ==========================================================
  // Assertions
  a_long: assert property (p_long)
    else $error("long jump stall length wrong");
  a_take: assert property (p_take)
    else $error("commit without a taken word");
  a_excl: assert property (p_excl)
    else $error("commit during a no-op cycle");
  a_bad: assert property (p_bad)
    else $error("bad pair not squashed");
  a_hold: assert property (p_hold)
    else $error("fields moved without commit");
  a_byte: assert property (p_byte)
    else $error("byte literal above 255");
  a_even: assert property (p_even)
    else $error("odd program address");
  a_bit: assert property (p_bit)
    else $error("bit select not one-hot of field");
  a_ptr: assert property (p_ptr)
    else $error("pointer step not two");
  a_zero: assert property (p_zero)
    else $error("chained result set zero");
  a_dsp: assert property (p_dsp)
    else $error("acc B flags moved on A update");
endmodule : ict_core_checker

bind ict_core ict_core_checker u_chk (
  .clk(clk), .srst(srst), .instr_valid(instr_valid), .instr_ready(instr_ready),
  .instr_word(instr_word), .instr_class(instr_class), .long_form(long_form),
  .byte_mode(byte_mode), .upd_mcu(upd_mcu), .chain(chain), .upd_dsp(upd_dsp),
  .acc_sel(acc_sel), .commit(commit), .exec_nop(exec_nop), .bad_pair(bad_pair),
  .operand_pair(operand_pair), .ten_bit_literal(ten_bit_literal),
  .program_address_literal(program_address_literal), .file_address(file_address),
  .bit_select_field(bit_select_field), .acc_writeback_target(acc_writeback_target),
  .writeback_pointer_reg(writeback_pointer_reg), .zero_flag(zero_flag),
  .acc_b_overflow_flag(acc_b_overflow_flag), .acc_b_clipped_flag(acc_b_clipped_flag)
);

`default_nettype wire

/* tb/tb_top.sv */
/*
  Self-checking bench for ict_core: fields, cycle counts, skips, pairs, flags.
  Assumes ict_pkg compiled first; inputs change 1 ns after the clock edge.
*/
`timescale 1ns/10ps
`default_nettype none

module tb_top
  import ict_pkg::*;
;
  logic clk = 0, srst = 1, iv = 0, cnd = 0, lf = 0, skt = 0, sk2 = 0, bm = 0;
  logic [23:0] w = '0;
  ict_class_e cls = CL_PLAIN;
  logic [10:0] fi = '0;
  logic rdy, cm, nop, bp, odd, wbt;
  logic [47:0] op;
  logic [9:0] l10;
  logic [22:0] pa;
  logic [15:0] sl, bs, ptr;
  logic [12:0] fa;
  wire logic [8:0] fl;
  int bad_count = 0, comparisons = 0;

  ict_core dut (.clk(clk), .srst(srst), .instr_valid(iv), .instr_word(w), .instr_class(cls),
    .cond_true(cnd), .long_form(lf), .skip_taken(skt), .skip_two_word(sk2), .byte_mode(bm),
    .upd_mcu(fi[10]), .chain(fi[9]), .res_c(fi[8]), .res_dc(fi[7]), .res_n(fi[6]),
    .res_ov(fi[5]), .res_zero(fi[4]), .upd_dsp(fi[3]), .acc_sel(fi[2]), .acc_ovf(fi[1]),
    .acc_sat(fi[0]), .instr_ready(rdy), .commit(cm), .exec_nop(nop), .bad_pair(bp),
    .operand_pair(op), .ten_bit_literal(l10), .program_address_literal(pa),
    .address_was_odd(odd), .signed_ten_bit_literal(sl), .file_address(fa),
    .bit_select_field(bs), .acc_writeback_target(wbt), .writeback_pointer_reg(ptr),
    .carry_flag(fl[8]), .digit_carry_flag(fl[7]), .negative_flag(fl[6]),
    .overflow_flag(fl[5]), .zero_flag(fl[4]), .acc_a_overflow_flag(fl[3]),
    .acc_b_overflow_flag(fl[2]), .acc_a_clipped_flag(fl[1]), .acc_b_clipped_flag(fl[0]));

  // ==========================================================
  // Clock and helpers
  always #12.5 clk = ~clk;

  task chk(input logic [47:0] s, input logic [47:0] e);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask : chk

  task test_done;
    $display("compares %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done

  task tick;
    @(posedge clk);
    #1;
  endtask : tick

  // Holds the word until the edge where ready is high, m = {cond,long,skip,skip2}
  task send(input logic [23:0] ww, input ict_class_e c, input logic [3:0] m);
    iv = 1;
    w = ww;
    cls = c;
    {cnd, lf, skt, sk2} = m;
    for (int i = 0; i < 9 && rdy !== 1'b1; i++) tick;
    tick;
  endtask : send

  // ==========================================================
  // Scenarios
  task t_field(input logic [23:0] ww, input logic b, input logic [54:0] e);
    bm = b;
    send(ww, CL_PLAIN, 4'h0);
    chk({cm, rdy}, 2'b11);
    chk(op, {ww, 24'h0});
    chk(l10, e[54:45]);
    chk(sl, e[44:29]);
    chk(fa, e[28:16]);
    chk(bs, e[15:0]);
  endtask : t_field

  // Counts stall and no-op cycles after one instruction
  task t_cyc(input ict_class_e c, input logic [3:0] m, input int n);
    int k, p;
    k = 0;
    p = 0;
    send(24'h800000, c, m);
    iv = 0;
    chk(cm, 1'b1);
    repeat (4) begin
      k += (rdy !== 1'b1);
      p += (nop === 1'b1);
      tick;
    end
    chk(k, n - 1);
    chk(p, n - 1);
  endtask : t_cyc

  task t_skip(input logic [3:0] m, input int n);
    send(24'h800000, CL_SKIP, m);
    chk(cm, 1'b1);
    repeat (n) begin
      send(24'h801234, CL_PLAIN, 4'h0);
      chk({cm, nop, fa}, {2'b01, 13'h0000});
    end
    send(24'h80abcd, CL_PLAIN, 4'h0);
    chk({cm, nop, fa}, {2'b10, 13'h0bcd});
  endtask : t_skip

  task t_pair;
    send(24'h813457, CL_DOUBLE, 4'h0);
    chk({cm, nop}, 2'b00);
    send(24'h000055, CL_DOUBLE, 4'h0);
    chk({cm, nop, op}, {2'b10, 24'h813457, 24'h000055});
    chk({pa, odd}, {23'h553456, 1'b1});
    chk({wbt, ptr}, {1'b1, 16'h0002});
    send(24'h801111, CL_DOUBLE, 4'h0);
    send(24'h010000, CL_DOUBLE, 4'h0);
    chk({cm, nop, bp}, 3'b011);
    send(24'h000077, CL_PLAIN, 4'h0);
    chk({cm, nop, bp, ptr}, {3'b010, 16'h0002});
    chk(op, {24'h813457, 24'h000055});
  endtask : t_pair

  task t_flag(input logic [10:0] v, input logic [8:0] e);
    fi = v;
    send(24'h800000, CL_PLAIN, 4'h0);
    chk(fl, e);
  endtask : t_flag

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    repeat (5) @(posedge clk);
    #1 srst = 0;
    chk({rdy, cm, nop, bp, ptr, fl}, {4'h8, 25'h0});
    t_field(24'h80f5a7, 1'b0, {10'h35a, 16'hff5a, 13'h15a7, 16'h8000});
    t_field(24'h80f5a7, 1'b1, {10'h05a, 16'hff5a, 13'h15a7, 16'h8000});
    t_field(24'h802000, 1'b1, {10'h000, 16'hfe00, 13'h0000, 16'h0004});
    t_field(24'h801fff, 1'b0, {10'h1ff, 16'h01ff, 13'h1fff, 16'h0002});
    t_cyc(CL_PLAIN, 4'h0, 1);
    t_cyc(CL_COND, 4'h0, 1);
    t_cyc(CL_COND, 4'h8, 2);
    t_cyc(CL_PCWRITE, 4'h0, 2);
    t_cyc(CL_JUMP, 4'h0, 2);
    t_cyc(CL_JUMP, 4'h4, 3);
    t_cyc(CL_INDIRECT, 4'h4, 3);
    t_cyc(CL_TABLE, 4'h0, 2);
    t_cyc(CL_RETURN, 4'h4, 3);
    t_cyc(CL_DMOVE, 4'h0, 2);
    t_skip(4'h2, 1);
    t_skip(4'h3, 2);
    t_skip(4'h0, 0);
    t_pair;
    t_flag(11'b10_11111_0000, 9'h1f0);
    t_flag(11'b11_00001_0000, 9'h010);
    t_flag(11'b11_00000_0000, 9'h000);
    t_flag(11'b11_00001_0000, 9'h000);
    t_flag(11'b00_00000_1011, 9'h00a);
    t_flag(11'b00_00000_1110, 9'h00e);
    t_flag(11'b00_11111_0000, 9'h00e);
    test_done;
  end

  // A hang costs a mismatch; the tests need well under 1000 cycles
  initial begin
    #50us;
    bad_count++;
    test_done;
  end
endmodule : tb_top

`default_nettype wire
